// File: include/psacr_phy_if.sv
`timescale 1ns/1ps
interface psacr_phy_if;
  logic link_up;
  logic an_done;
  logic cable_done;
  logic [psacr_pkg::PART_W-1:0] partner;
  logic [psacr_pkg::RES_W-1:0] cable_result;
  logic [psacr_pkg::FAULT_W-1:0] fault_count;
  modport sync_side (output link_up, an_done, cable_done, partner, cable_result, fault_count);
  modport regs_side (input link_up, an_done, cable_done, partner, cable_result, fault_count);
endinterface

// File: include/psacr_pkg.sv
package psacr_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int IDX_W = ADDR_W - 2;

  // register indices as printed; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BASIC_STATUS = 10'h0E6;
  localparam logic [IDX_W-1:0] IDX_ID_LOW = 10'h0E8;
  localparam logic [IDX_W-1:0] IDX_ID_HIGH = 10'h0EA;
  localparam logic [IDX_W-1:0] IDX_ADVERTISE = 10'h0EC;
  localparam logic [IDX_W-1:0] IDX_PARTNER = 10'h0EE;
  localparam logic [IDX_W-1:0] IDX_CABLE_DIAG = 10'h0F4;
  localparam logic [IDX_W-1:0] IDX_PORT_CONTROL = 10'h0F6;
  localparam logic [IDX_W-1:0] IDX_PORT_STATUS = 10'h0F8;

  // slots of the read-word table
  localparam logic [2:0] SLOT_BASIC = 3'h0;
  localparam logic [2:0] SLOT_ID_LOW = 3'h1;
  localparam logic [2:0] SLOT_ID_HIGH = 3'h2;
  localparam logic [2:0] SLOT_ADV = 3'h3;
  localparam logic [2:0] SLOT_PARTNER = 3'h4;
  localparam logic [2:0] SLOT_CABLE = 3'h5;
  localparam logic [2:0] SLOT_PC = 3'h6;
  localparam logic [2:0] SLOT_PS = 3'h7;

  // basic status layout
  localparam logic [15:0] BS_FIXED = 16'h7808;
  localparam int BS_AN_DONE = 5;
  localparam int BS_LINK = 2;

  // advertisement and partner layout
  localparam int ADV_PAUSE = 10;
  localparam int ADV_ABIL_LSB = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [4:0] ADV_RESET = 5'h1F;
  localparam logic [4:0] LP_LOW_FIXED = 5'h01;

  // cable diagnostic layout
  localparam int CD_RESULT_LSB = 13;
  localparam int CD_START = 12;
  localparam int CD_FORCE_LINK = 11;
  localparam int CD_REMOTE_LOOP = 9;
  localparam logic [1:0] CR_NORMAL = 2'h0;
  localparam logic [1:0] CR_OPEN = 2'h1;
  localparam logic [1:0] CR_SHORT = 2'h2;
  localparam logic [1:0] CR_FAILED = 2'h3;

  // port control / port status layout
  localparam int PC_RESTART = 13;
  localparam logic [10:0] PC_HI_RESET = 11'h007;
  localparam logic [10:0] PC_HI_WMASK = 11'h6FF;
  localparam int PS_AN_DONE = 6;
  localparam int PS_LINK = 5;

  // synchronised phy-side bundle
  localparam int PART_W = 5;
  localparam int RES_W = 2;
  localparam int FAULT_W = 9;
  localparam int SY_LINK = 0;
  localparam int SY_AN = 1;
  localparam int SY_DONE = 2;
  localparam int SY_PART_LSB = 3;
  localparam int SY_RES_LSB = 8;
  localparam int SY_FAULT_LSB = 10;
  localparam int SYNC_W = 19;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 19'h00000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    PSACR_CT_IDLE = 3'b001,
    PSACR_CT_ARM = 3'b010,
    PSACR_CT_RUN = 3'b100
  } psacr_cable_e;

endpackage

// File: logic/psacr_sync.sv
`timescale 1ns/1ps
module psacr_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [psacr_pkg::SYNC_W-1:0] raw_in,
  psacr_phy_if.sync_side phy
);
  import psacr_pkg::*;

  logic [SYNC_W-1:0] stage1_reg;
  logic [SYNC_W-1:0] stage2_reg;
  logic [SYNC_W-1:0] stage3_reg;
  logic [SYNC_W-1:0] stable_reg;

  // three-flop chain; stage1 feeds only stage2
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1_reg <= SYNC_RESET;
      stage2_reg <= SYNC_RESET;
      stage3_reg <= SYNC_RESET;
    end
    else
    begin
      stage1_reg <= raw_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a bit changes only once two late stages agree, filtering one-cycle glitches
  genvar i;
  for (i = 0; i < SYNC_W; i++)
  begin : g_bit
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        stable_reg[i] <= 1'b0;
      else if (stage2_reg[i] == stage3_reg[i])
        stable_reg[i] <= stage3_reg[i];
    end
  end

  // unpack into named fields
  assign phy.link_up = stable_reg[SY_LINK];
  assign phy.an_done = stable_reg[SY_AN];
  assign phy.cable_done = stable_reg[SY_DONE];
  assign phy.partner = stable_reg[SY_PART_LSB +: PART_W];
  assign phy.cable_result = stable_reg[SY_RES_LSB +: RES_W];
  assign phy.fault_count = stable_reg[SY_FAULT_LSB +: FAULT_W];
endmodule

// File: logic/psacr_top.sv
// Overview of operation
// - basic status bit 15 reads 0, no T4 capability, read-only.
// - basic status bits 14 to 11 read 1, all four speed/duplex abilities.
// - preamble suppression bit 6 and jabber bit 1 always read 0.
// - bit 5 shows negotiation complete, same as port status bit 6.
// - basic status bit 3 reads 1, negotiation capable.
// - bit 2 shows current link state, same as port status bit 5.
// - basic status bit 0 reads 0, no extended registers.
// - two fixed read-only identifier words, low and high.
// - advertised pause bit 10 writable, resets to 1, shared with control bit 4.
// - advertised bits 8 to 5 writable, reset 1, shared with control bits 3..0.
// - selector field reads 0x01; next page and remote fault read 0.
// - partner word shows partner pause and four abilities, mirrored in status 4..0.
// - cable result bits 14:13: normal, open, short, failed.
// - writing 1 to bit 12 starts the cable test; cleared when test ends.
// - cable bits 8 to 0 hold fault distance count, read-only.
// - writing port control mirror bits changes advertisement bits, same storage.
`timescale 1ns/1ps
module psacr_top #(
  parameter logic [15:0] PHY_ID_LOW = 16'hA5C3, // arbitrary value
  parameter logic [15:0] PHY_ID_HIGH = 16'h5A3C // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [psacr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [psacr_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic phy_link_up,
  input wire logic phy_an_done,
  input wire logic [psacr_pkg::PART_W-1:0] phy_partner_ability,
  input wire logic cable_done,
  input wire logic [psacr_pkg::RES_W-1:0] cable_result,
  input wire logic [psacr_pkg::FAULT_W-1:0] cable_fault_count,
  output logic [4:0] adv_ability,
  output logic an_restart,
  output logic cable_test_en,
  output logic force_link,
  output logic remote_loopback
);
  import psacr_pkg::*;

  psacr_phy_if phy ();

  logic aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [4:0] adv_reg;
  logic [10:0] pc_hi_reg;
  logic an_restart_reg;
  logic an_wait_reg;
  logic an_done_reg;
  logic [PART_W-1:0] partner_reg;
  psacr_cable_e cable_state_reg;
  logic [RES_W-1:0] result_reg;
  logic [FAULT_W-1:0] fault_reg;
  logic force_link_reg;
  logic remote_loop_reg;
  logic [15:0] words [0:7];
  logic wr_fire;
  logic [IDX_W-1:0] wr_idx;
  logic [3:0] wr_map;
  logic [3:0] rd_map;
  logic [15:0] wr_mask;
  logic [15:0] merged;
  logic restart_req;
  logic start_req;
  logic cable_busy;

  // index to {hit, slot}; anything else is unmapped
  function automatic logic [3:0] map_slot(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_BASIC_STATUS: map_slot = {1'b1, SLOT_BASIC};
      IDX_ID_LOW: map_slot = {1'b1, SLOT_ID_LOW};
      IDX_ID_HIGH: map_slot = {1'b1, SLOT_ID_HIGH};
      IDX_ADVERTISE: map_slot = {1'b1, SLOT_ADV};
      IDX_PARTNER: map_slot = {1'b1, SLOT_PARTNER};
      IDX_CABLE_DIAG: map_slot = {1'b1, SLOT_CABLE};
      IDX_PORT_CONTROL: map_slot = {1'b1, SLOT_PC};
      IDX_PORT_STATUS: map_slot = {1'b1, SLOT_PS};
      default: map_slot = 4'h0;
    endcase
  endfunction

  // pin inputs go through the three-stage filter
  psacr_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in({cable_fault_count, cable_result, phy_partner_ability,
             cable_done, phy_an_done, phy_link_up}),
    .phy(phy)
  );

  // read-word table; only stored bits come from flops, fixed bits are constants
  always_comb
  begin
    words[SLOT_BASIC] = BS_FIXED;
    words[SLOT_BASIC][BS_AN_DONE] = an_done_reg;
    words[SLOT_BASIC][BS_LINK] = phy.link_up;
    words[SLOT_ID_LOW] = PHY_ID_LOW;
    words[SLOT_ID_HIGH] = PHY_ID_HIGH;
    words[SLOT_ADV] = 16'h0000;
    words[SLOT_ADV][ADV_PAUSE] = adv_reg[4];
    words[SLOT_ADV][ADV_ABIL_LSB +: 4] = adv_reg[3:0];
    words[SLOT_ADV][4:0] = ADV_SELECTOR;
    words[SLOT_PARTNER] = 16'h0000;
    words[SLOT_PARTNER][ADV_PAUSE] = partner_reg[4];
    words[SLOT_PARTNER][ADV_ABIL_LSB +: 4] = partner_reg[3:0];
    words[SLOT_PARTNER][4:0] = LP_LOW_FIXED;
    words[SLOT_CABLE] = 16'h0000;
    words[SLOT_CABLE][CD_RESULT_LSB +: RES_W] = result_reg;
    words[SLOT_CABLE][CD_START] = cable_busy;
    words[SLOT_CABLE][CD_FORCE_LINK] = force_link_reg;
    words[SLOT_CABLE][CD_REMOTE_LOOP] = remote_loop_reg;
    words[SLOT_CABLE][FAULT_W-1:0] = fault_reg;
    words[SLOT_PC] = {pc_hi_reg, adv_reg};
    words[SLOT_PS] = 16'h0000;
    words[SLOT_PS][PS_AN_DONE] = an_done_reg;
    words[SLOT_PS][PS_LINK] = phy.link_up;
    words[SLOT_PS][PART_W-1:0] = partner_reg;
  end

  // write decode: merge byte lanes into the current word, so unwritten bytes keep value
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_idx = aw_addr_reg[ADDR_W-1:2];
  assign wr_map = map_slot(wr_idx);
  assign rd_map = map_slot(s_axi_araddr[ADDR_W-1:2]);
  assign wr_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign merged = (words[wr_map[2:0]] & ~wr_mask) | (w_data_reg[15:0] & wr_mask);
  assign restart_req = wr_fire && wr_map == {1'b1, SLOT_PC} && merged[PC_RESTART];
  assign start_req = wr_fire && wr_map == {1'b1, SLOT_CABLE} && w_strb_reg[1]
                     && w_data_reg[CD_START];
  assign cable_busy = cable_state_reg != PSACR_CT_IDLE;

  // handshake outputs are combinational; one address and one data held at a time
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_full_reg <= 1'b0;
      if (s_axi_wvalid && !w_full_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_full_reg <= 1'b0;
    end
  end

  // write response; unmapped words answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_map[3] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_map[3] ? {16'h0000, words[rd_map[2:0]]} : 32'h00000000;
      rresp_reg <= rd_map[3] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // advertisement storage reached from two addresses; fixed bits never stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adv_reg <= ADV_RESET;
    else if (wr_fire && wr_map == {1'b1, SLOT_ADV})
      adv_reg <= {merged[ADV_PAUSE], merged[ADV_ABIL_LSB +: 4]};
    else if (wr_fire && wr_map == {1'b1, SLOT_PC})
      adv_reg <= merged[4:0];
  end

  // upper port control bits; restart never stored so it reads back 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_hi_reg <= PC_HI_RESET;
      an_restart_reg <= 1'b0;
    end
    else
    begin
      an_restart_reg <= restart_req;
      if (wr_fire && wr_map == {1'b1, SLOT_PC})
        pc_hi_reg <= merged[15:5] & PC_HI_WMASK;
    end
  end

  // negotiation result; after a restart the stale done level is ignored until it drops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      an_wait_reg <= 1'b0;
      an_done_reg <= 1'b0;
      partner_reg <= '0;
    end
    else
    begin
      if (restart_req)
        an_wait_reg <= 1'b1;
      else if (!phy.an_done)
        an_wait_reg <= 1'b0;
      if (restart_req || !phy.link_up)
      begin
        an_done_reg <= 1'b0;
        partner_reg <= '0;
      end
      else if (phy.an_done && !an_wait_reg && !an_done_reg)
      begin
        an_done_reg <= 1'b1;
        partner_reg <= phy.partner;
      end
    end
  end

  // cable test: arm waits for done low so a stale done cannot end a new test
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cable_state_reg <= PSACR_CT_IDLE;
      result_reg <= CR_NORMAL;
      fault_reg <= '0;
    end
    else
    begin
      case (cable_state_reg)
        PSACR_CT_IDLE:
          if (start_req)
            cable_state_reg <= PSACR_CT_ARM;
        PSACR_CT_ARM:
          if (!phy.cable_done)
            cable_state_reg <= PSACR_CT_RUN;
        PSACR_CT_RUN:
          if (phy.cable_done)
          begin
            // results land in the same edge the busy bit drops
            result_reg <= phy.cable_result;
            fault_reg <= phy.fault_count;
            cable_state_reg <= start_req ? PSACR_CT_ARM : PSACR_CT_IDLE;
          end
        default:
          cable_state_reg <= PSACR_CT_IDLE;
      endcase
    end
  end

  // special control bits beside the cable test
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      force_link_reg <= 1'b0;
      remote_loop_reg <= 1'b0;
    end
    else if (wr_fire && wr_map == {1'b1, SLOT_CABLE})
    begin
      force_link_reg <= merged[CD_FORCE_LINK];
      remote_loop_reg <= merged[CD_REMOTE_LOOP];
    end
  end

  // outputs toward the phy; cable_test_en decoded from the cable state, the rest straight from flops
  assign adv_ability = adv_reg;
  assign an_restart = an_restart_reg;
  assign cable_test_en = cable_busy;
  assign force_link = force_link_reg;
  assign remote_loopback = remote_loop_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_test_start;
    start_req && cable_state_reg == PSACR_CT_IDLE;
  endsequence

  sequence s_test_end;
    cable_state_reg == PSACR_CT_RUN && phy.cable_done && !start_req;
  endsequence

  // only a basic status read is held to bit 15 low; other words may use that bit
  a_t4_absent:
    assert property (s_axi_arvalid && s_axi_arready && rd_map == {1'b1, SLOT_BASIC}
                     |=> !s_axi_rdata[15] && !words[SLOT_BASIC][15])
    else $error("t4 bit not zero");
  a_fixed_caps:
    assert property (words[SLOT_BASIC][14:11] == 4'hF && words[SLOT_BASIC][3])
    else $error("capability bits wrong");
  a_unsup_zero:
    assert property (!words[SLOT_BASIC][6] && !words[SLOT_BASIC][1] && !words[SLOT_BASIC][0])
    else $error("unsupported bit set");
  a_an_mirror:
    assert property ($rose(an_done_reg) |-> $past(phy.an_done) && words[SLOT_PS][PS_AN_DONE])
    else $error("negotiation done not from phy");
  a_link_mirror:
    assert property (words[SLOT_BASIC][BS_LINK] == words[SLOT_PS][PS_LINK])
    else $error("link mirrors disagree");
  a_id_fixed:
    assert property (words[SLOT_ID_LOW] == PHY_ID_LOW && words[SLOT_ID_HIGH] == PHY_ID_HIGH)
    else $error("identifier changed");
  a_sel_fixed:
    assert property (words[SLOT_ADV][4:0] == 5'h01 && words[SLOT_ADV][15:11] == 5'h00)
    else $error("selector or upper bits wrong");
  a_test_busy:
    assert property (s_test_start |=> cable_busy [*2])
    else $error("test start not held busy");
  a_test_clear:
    assert property (s_test_end |=> !cable_busy && result_reg == $past(phy.cable_result))
    else $error("test end not cleared");
  a_fault_load:
    assert property (s_test_end |=> fault_reg == $past(phy.fault_count))
    else $error("fault count not captured");
  a_shared_adv:
    assert property (wr_fire && wr_map == {1'b1, SLOT_PC} && w_strb_reg[0]
                     |=> words[SLOT_ADV][8:5] == $past(w_data_reg[3:0]))
    else $error("control write missed advertisement");
  a_an_drop:
    assert property (!phy.link_up || restart_req |=> !an_done_reg && partner_reg == 5'h00)
    else $error("negotiation state kept");
  a_resp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import psacr_pkg::*;
  localparam logic [15:0] ID_LO = 16'h3C5A; // arbitrary value
  localparam logic [15:0] ID_HI = 16'h6B17; // arbitrary value
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic link = 1'b0, an = 1'b0, cdone = 1'b0;
  logic [PART_W-1:0] part = '0;
  logic [RES_W-1:0] cres = '0;
  logic [FAULT_W-1:0] cflt = '0;
  logic [4:0] adv_ability;
  logic an_restart, cable_test_en, force_link, remote_loopback;
  int err_count = 0, num_checks = 0, cyc = 0, pulses = 0;
  int adv_m = 31;
  logic [15:0] rnd = 16'h004E;
  logic [15:0] d, s;

  always #5 aclk = ~aclk;

  psacr_top #(.PHY_ID_LOW(ID_LO), .PHY_ID_HIGH(ID_HI)) psacr_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .phy_link_up(link), .phy_an_done(an), .phy_partner_ability(part),
    .cable_done(cdone), .cable_result(cres), .cable_fault_count(cflt),
    .adv_ability(adv_ability), .an_restart(an_restart), .cable_test_en(cable_test_en),
    .force_link(force_link), .remote_loopback(remote_loopback)
  );

  // 16-bit shift register, fixed start so runs repeat
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // one write; address and data offered together, bready raised early
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] v, input logic [3:0] st,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready && !aw_ok)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready && !w_ok)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  // one read; masked data and response compared with the model
  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] m,
                        input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    rready <= 1'b0;
    check(rdata & m, exp, "read data");
    check({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  function automatic logic [31:0] adv_word(input int a);
    return 32'h1 | ((a >> 4) & 1) << 10 | (a & 15) << 5;
  endfunction

  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask

  // hang guard, well above the expected run length
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  always @(posedge aclk)
    if (an_restart === 1'b1)
      pulses++;

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(IDX_BASIC_STATUS, '1, 32'h7808, RESP_OKAY);
    rd_chk(IDX_ID_LOW, '1, {16'h0, ID_LO}, RESP_OKAY);
    rd_chk(IDX_ID_HIGH, '1, {16'h0, ID_HI}, RESP_OKAY);
    rd_chk(IDX_ADVERTISE, '1, 32'h05E1, RESP_OKAY);
    rd_chk(IDX_PARTNER, '1, 32'h0001, RESP_OKAY);
    rd_chk(IDX_CABLE_DIAG, '1, 32'h0, RESP_OKAY);
    check({27'h0, adv_ability}, 32'h1F, "adv reset");
    // read-only words ignore writes
    wr(IDX_BASIC_STATUS, 16'h87F7, 4'hF, RESP_OKAY);
    wr(IDX_ID_LOW, ~ID_LO, 4'hF, RESP_OKAY);
    wr(IDX_PARTNER, 16'hFFFF, 4'hF, RESP_OKAY);
    rd_chk(IDX_BASIC_STATUS, '1, 32'h7808, RESP_OKAY);
    rd_chk(IDX_ID_LOW, '1, {16'h0, ID_LO}, RESP_OKAY);
    rd_chk(IDX_PARTNER, '1, 32'h0001, RESP_OKAY);
    // random advert writes with partial strobes; read-only bits stay put
    repeat (8)
    begin
      rnd = lfsr(rnd);
      d = rnd;
      rnd = lfsr(rnd);
      s = (rnd[1:0] == 2'b00) ? 16'h3 : {14'h0, rnd[1:0]};
      wr(IDX_ADVERTISE, d, s[3:0], RESP_OKAY);
      if (s[0])
        adv_m = (adv_m & 24) | ((d >> 5) & 7);
      if (s[1])
        adv_m = (adv_m & 7) | ((d >> 10) & 1) << 4 | ((d >> 8) & 1) << 3;
      rd_chk(IDX_ADVERTISE, '1, adv_word(adv_m), RESP_OKAY);
      rd_chk(IDX_PORT_CONTROL, 32'h1F, adv_m, RESP_OKAY);
      check({27'h0, adv_ability}, adv_m, "adv output");
    end
    // port control mirror writes reach the advertisement
    repeat (4)
    begin
      rnd = lfsr(rnd);
      adv_m = rnd[4:0];
      wr(IDX_PORT_CONTROL, 16'h00E0 | rnd[4:0], 4'h3, RESP_OKAY);
      rd_chk(IDX_ADVERTISE, '1, adv_word(adv_m), RESP_OKAY);
    end
    // link up with negotiation finished
    rnd = lfsr(rnd);
    link <= 1'b1;
    an <= 1'b1;
    part <= rnd[4:0];
    settle();
    rd_chk(IDX_BASIC_STATUS, '1, 32'h782C, RESP_OKAY);
    rd_chk(IDX_PARTNER, '1, adv_word(rnd[4:0]), RESP_OKAY);
    rd_chk(IDX_PORT_STATUS, 32'h7F, 32'h60 | rnd[4:0], RESP_OKAY);
    // restart clears done and partner until a fresh completion
    pulses = 0;
    wr(IDX_PORT_CONTROL, 16'h20E0 | adv_m, 4'h3, RESP_OKAY);
    settle();
    check(pulses, 1, "restart pulse");
    rd_chk(IDX_BASIC_STATUS, '1, 32'h780C, RESP_OKAY);
    rd_chk(IDX_PARTNER, '1, 32'h0001, RESP_OKAY);
    an <= 1'b0;
    settle();
    an <= 1'b1;
    settle();
    rd_chk(IDX_BASIC_STATUS, '1, 32'h782C, RESP_OKAY);
    // link loss drops everything
    link <= 1'b0;
    settle();
    rd_chk(IDX_BASIC_STATUS, '1, 32'h7808, RESP_OKAY);
    rd_chk(IDX_PARTNER, '1, 32'h0001, RESP_OKAY);
    rd_chk(IDX_PORT_STATUS, 32'h7F, 32'h0, RESP_OKAY);
    an <= 1'b0;
    // cable test with every result code
    for (int r = 0; r < 4; r++)
    begin
      rnd = lfsr(rnd);
      cres <= r[1:0];
      cflt <= rnd[8:0];
      settle();
      wr(IDX_CABLE_DIAG, 16'h1000, 4'h3, RESP_OKAY);
      check({31'h0, cable_test_en}, 32'h1, "test busy");
      rd_chk(IDX_CABLE_DIAG, 32'h1000, 32'h1000, RESP_OKAY);
      cdone <= 1'b1;
      for (int k = 0; k < 50 && cable_test_en !== 1'b0; k++)
        @(posedge aclk);
      check({31'h0, cable_test_en}, 32'h0, "test end");
      rd_chk(IDX_CABLE_DIAG, '1, (r << 13) | rnd[8:0], RESP_OKAY);
      cdone <= 1'b0;
    end
    // control bits writable, result and count not
    wr(IDX_CABLE_DIAG, 16'h0A00, 4'h3, RESP_OKAY);
    check({30'h0, force_link, remote_loopback}, 32'h3, "special control");
    rd_chk(IDX_CABLE_DIAG, '1, 32'h6A00 | rnd[8:0], RESP_OKAY);
    wr(IDX_CABLE_DIAG, 16'h81FF, 4'h3, RESP_OKAY);
    rd_chk(IDX_CABLE_DIAG, '1, 32'h6000 | rnd[8:0], RESP_OKAY);
    // unmapped place answers with an error
    wr(10'h000, 16'hFFFF, 4'hF, RESP_SLVERR);
    rd_chk(10'h000, '1, 32'h0, RESP_SLVERR);
    end_sim();
  end
endmodule
